// ==== common/quad_timer_pkg.sv ====
package quad_timer_pkg;
  localparam int unsigned DIV_SYS_12 = 12;
  localparam int unsigned DIV_SYS_4 = 4;
  localparam int unsigned DIV_SYS_48 = 48;
  localparam int unsigned DIV_OSC_8 = 8;
  localparam int unsigned NUM_DIV = 5;
  localparam int unsigned TK_D12 = 0;
  localparam int unsigned TK_D4 = 1;
  localparam int unsigned TK_D48 = 2;
  localparam int unsigned TK_EXT8 = 3;
  localparam int unsigned TK_RTC8 = 4;
  localparam int unsigned DIV_TABLE [NUM_DIV] = '{DIV_SYS_12, DIV_SYS_4, DIV_SYS_48, DIV_OSC_8, DIV_OSC_8};
  localparam int unsigned NUM_IN = 8;
  localparam int unsigned IN_EV0 = 0;
  localparam int unsigned IN_G0 = 2;
  localparam int unsigned IN_EXT = 4;
  localparam int unsigned IN_RTC = 5;
  localparam int unsigned IN_CMP0 = 6;
  localparam logic [7:0] ADR_CLKCTL = 8'h00;
  localparam logic [7:0] ADR_CLASSIC = 8'h04;
  localparam logic [7:0] ADR_CNT0 = 8'h08;
  localparam logic [7:0] ADR_CNT1 = 8'h0C;
  localparam logic [7:0] ADR_ACTL2 = 8'h10;
  localparam logic [7:0] ADR_ACNT2 = 8'h14;
  localparam logic [7:0] ADR_ARLD2 = 8'h18;
  localparam logic [7:0] ADR_ACTL3 = 8'h1C;
  localparam logic [7:0] ADR_ACNT3 = 8'h20;
  localparam logic [7:0] ADR_ARLD3 = 8'h24;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h28;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h2C;
  localparam logic [7:0] ADR_IRQ_EN = 8'h30;
  localparam int unsigned CLS1_LSB = 8;
  localparam logic [12:0] CNT13_TOP = 13'h1FFF;
  localparam logic [15:0] CNT16_TOP = 16'hFFFF;
  localparam logic [7:0] CNT8_TOP = 8'hFF;
  localparam int unsigned ST_OVF0 = 0;
  localparam int unsigned ST_OVF1 = 1;
  localparam int unsigned ST_LO2 = 2;
  localparam int unsigned ST_HI2 = 3;
  localparam int unsigned ST_CAP2 = 6;
  localparam logic [7:0] CLKCTL_RST = 8'h00;
  localparam logic [5:0] CLS_RST = 6'h00;
  localparam logic [5:0] ACTL_RST = 6'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [7:0] IRQ_RST = 8'h00;

  typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_8BIT_RELOAD, MODE_SPLIT} classic_mode_t;
  typedef enum logic [1:0] {PRE_DIV12, PRE_DIV4, PRE_DIV48, PRE_EXT8} prescale_t;
  typedef enum logic [1:0] {XCLK_SYS12, XCLK_OSC8, XCLK_CMP, XCLK_NONE} aux_clk_t;

  typedef struct packed {
    logic t3_hi_sys;
    logic t3_lo_sys;
    logic t2_hi_sys;
    logic t2_lo_sys;
    logic timer1_sysclk_select;
    logic timer0_sysclk_select;
    prescale_t shared_prescale_select;
  } clk_ctl_t;

  typedef struct packed {
    logic gate_polarity;
    logic run_bit;
    logic gate_enable;
    logic counter_select;
    classic_mode_t mode;
  } classic_ctl_t;

  typedef struct packed {
    logic cap_src;
    logic cap_en;
    aux_clk_t xclk;
    logic split;
    logic run;
  } auto_ctl_t;
endpackage : quad_timer_pkg

// ==== rtl/edge_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic din,
  output logic level,
  output logic fall,
  output logic rise
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign fall = prev_q & ~sync_q;
  assign rise = ~prev_q & sync_q;

  fall_one_shot_a: assert property (@(posedge clk) disable iff (sys_rst) fall |=> !fall)
    else $error("falling edge pulse lasted more than one cycle");
endmodule : edge_sync
`default_nettype wire

// ==== rtl/tick_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int unsigned DIV = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick_in,
  output logic tick_out
);
  localparam int unsigned W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_q;
  logic tick_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (tick_in) begin
        if (cnt_q == LAST) begin
          cnt_q <= '0;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  assign tick_out = tick_q;

  tick_single_a: assert property (@(posedge clk) disable iff (sys_rst) tick_q |=> !tick_q)
    else $error("divided tick lasted more than one cycle");
endmodule : tick_divider
`default_nettype wire

// ==== rtl/quad_timer_top.sv ====
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Four 16-bit counter/timers exist, two classic ones and two auto-reload ones.
// - Classic timers run as 13-bit, 16-bit or 8-bit auto-reload, and timer 0 also as two 8-bit halves.
// - Auto-reload timers run as one 16-bit reload timer or as two 8-bit reload halves.
// - Auto-reload timers can capture their count on edges of the slow oscillator or a comparator.
// - The classic timer clock comes from one of five sources via sysclk select and shared prescale.
// - Each classic timer picks either the shared prescaled tick or the full system clock.
// - Auto-reload timers can tick on the system clock or on the system clock divided by 12.
// - Timer 2 can also tick on the slow oscillator divided by 8 or on comparator 0.
// - Timer 3 can also tick on the external oscillator divided by 8 or on comparator 1.
// - In counter operation a classic timer steps once per falling edge of its event pin.
// - Event rates up to a quarter of the system clock are counted without loss.
// - Prescale field picks system clock over 12, 4, 48, or external oscillator over 8.
// - With counter select set, the sysclk select is ignored and the event pin drives the count.
// - A classic timer counts only while run is set and the gate is off or at its active level; timer 0's upper half in split mode needs only timer 1's run bit.
// - In 13-bit mode a wrap from 0x1FFF to 0x0000 sets the overflow flag.
module quad_timer_top
  import quad_timer_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic event_input_zero,
  input wire logic event_input_one,
  input wire logic gate_input_zero,
  input wire logic gate_input_one,
  input wire logic ext_osc_in,
  input wire logic rtc_osc_in,
  input wire logic comparator0_in,
  input wire logic comparator1_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] dat,
                                          input logic [1:0] sel);
    merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : merge16

  // Returns the overflow bit above the next count value of a classic timer.
  function automatic logic [16:0] classic_step(input classic_mode_t m, input logic [15:0] c);
    logic [12:0] c13;
    logic [16:0] r;
    c13 = {c[15:8], c[4:0]} + 13'h0001;
    r = {1'b0, c};
    case (m)
      MODE_13BIT: r = {({c[15:8], c[4:0]} == CNT13_TOP), c13[12:5], c[7:5], c13[4:0]};
      MODE_16BIT: r = {(c == CNT16_TOP), c + 16'h0001};
      MODE_8BIT_RELOAD: begin
        if (c[7:0] == CNT8_TOP) begin
          r = {1'b1, c[15:8], c[15:8]};
        end else begin
          r = {1'b0, c[15:8], c[7:0] + 8'h01};
        end
      end
      default: r = {(c[7:0] == CNT8_TOP), c[15:8], c[7:0] + 8'h01};
    endcase
    classic_step = r;
  endfunction : classic_step

  function automatic logic aux_tick(input aux_clk_t x, input logic d12, input logic osc8, input logic cmp);
    case (x)
      XCLK_SYS12: aux_tick = d12;
      XCLK_OSC8: aux_tick = osc8;
      XCLK_CMP: aux_tick = cmp;
      default: aux_tick = 1'b0;
    endcase
  endfunction : aux_tick

  logic [NUM_IN-1:0] raw_in;
  logic [NUM_IN-1:0] lvl;
  logic [NUM_IN-1:0] fall;
  logic [NUM_IN-1:0] rise;
  logic [NUM_DIV-1:0] div_in;
  logic [NUM_DIV-1:0] tk;

  assign raw_in = {comparator1_in, comparator0_in, rtc_osc_in, ext_osc_in,
                   gate_input_one, gate_input_zero, event_input_one, event_input_zero};

  // Every pin is sampled on clk; levels held two cycles are never missed.
  for (genvar g = 0; g < NUM_IN; g++) begin : g_sync
    edge_sync u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .din(raw_in[g]),
      .level(lvl[g]),
      .fall(fall[g]),
      .rise(rise[g])
    );
  end

  assign div_in = {fall[IN_RTC], fall[IN_EXT], 3'b111};

  for (genvar g = 0; g < NUM_DIV; g++) begin : g_div
    tick_divider #(.DIV(DIV_TABLE[g])) u_div (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick_in(div_in[g]),
      .tick_out(tk[g])
    );
  end

  logic ack_q;
  logic [31:0] rdat_q;
  logic irq_q;
  clk_ctl_t clkctl_q;
  classic_ctl_t cls_q [2];
  logic [15:0] ccnt_q [2];
  auto_ctl_t actl_q [2];
  logic [15:0] acnt_q [2];
  logic [15:0] arld_q [2];
  logic [7:0] stat_q;
  logic [7:0] stat_d;
  logic [7:0] irq_en_q;

  logic acc;
  logic wr;
  logic wr_clk;
  logic wr_cls;
  logic wr_clr;
  logic wr_en;
  logic [1:0] wr_ccnt;
  logic [1:0] wr_actl;
  logic [1:0] wr_acnt;
  logic [1:0] wr_arld;
  logic [31:0] rd_val;

  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = acc & wb_we_i;

  always_comb begin
    wr_clk = 1'b0;
    wr_cls = 1'b0;
    wr_clr = 1'b0;
    wr_en = 1'b0;
    wr_ccnt = 2'b00;
    wr_actl = 2'b00;
    wr_acnt = 2'b00;
    wr_arld = 2'b00;
    rd_val = 32'h00000000;
    if (wb_adr_i == ADR_CLKCTL) begin
      wr_clk = wr;
      rd_val = {24'h000000, clkctl_q};
    end else if (wb_adr_i == ADR_CLASSIC) begin
      wr_cls = wr;
      rd_val = {18'h00000, cls_q[1], 2'h0, cls_q[0]};
    end else if (wb_adr_i == ADR_CNT0 || wb_adr_i == ADR_CNT1) begin
      wr_ccnt[wb_adr_i[2]] = wr;
      rd_val = {16'h0000, ccnt_q[wb_adr_i[2]]};
    end else if (wb_adr_i == ADR_ACTL2 || wb_adr_i == ADR_ACTL3) begin
      wr_actl[wb_adr_i[3]] = wr;
      rd_val = {26'h0000000, actl_q[wb_adr_i[3]]};
    end else if (wb_adr_i == ADR_ACNT2 || wb_adr_i == ADR_ACNT3) begin
      wr_acnt[wb_adr_i[5]] = wr;
      rd_val = {16'h0000, acnt_q[wb_adr_i[5]]};
    end else if (wb_adr_i == ADR_ARLD2 || wb_adr_i == ADR_ARLD3) begin
      wr_arld[wb_adr_i[5]] = wr;
      rd_val = {16'h0000, arld_q[wb_adr_i[5]]};
    end else if (wb_adr_i == ADR_IRQ_STAT) begin
      rd_val = {24'h000000, stat_q};
    end else if (wb_adr_i == ADR_IRQ_CLR) begin
      wr_clr = wr;
    end else if (wb_adr_i == ADR_IRQ_EN) begin
      wr_en = wr;
      rd_val = {24'h000000, irq_en_q};
    end
  end

  // Unmapped addresses still acknowledge so a stray access never hangs the bus.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= acc;
      if (acc) begin
        rdat_q <= rd_val;
      end
    end
  end

  ack_pulse_a: assert property (ack_q |=> !ack_q)
    else $error("bus acknowledge held for more than one cycle");

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkctl_q <= clk_ctl_t'(CLKCTL_RST);
      cls_q[0] <= classic_ctl_t'(CLS_RST);
      cls_q[1] <= classic_ctl_t'(CLS_RST);
      actl_q[0] <= auto_ctl_t'(ACTL_RST);
      actl_q[1] <= auto_ctl_t'(ACTL_RST);
      irq_en_q <= IRQ_RST;
    end else begin
      if (wr_clk && wb_sel_i[0]) begin
        clkctl_q <= clk_ctl_t'(wb_dat_i[7:0]);
      end
      if (wr_cls && wb_sel_i[0]) begin
        cls_q[0] <= classic_ctl_t'(wb_dat_i[5:0]);
      end
      if (wr_cls && wb_sel_i[1]) begin
        cls_q[1] <= classic_ctl_t'(wb_dat_i[CLS1_LSB+5:CLS1_LSB]);
      end
      for (int j = 0; j < 2; j++) begin
        if (wr_actl[j] && wb_sel_i[0]) begin
          actl_q[j] <= auto_ctl_t'(wb_dat_i[5:0]);
        end
      end
      if (wr_en && wb_sel_i[0]) begin
        irq_en_q <= wb_dat_i[7:0];
      end
    end
  end

  // Classic timers: clock choice, gating and stepping.
  logic counter_select_zero;
  logic run_bit_zero;
  logic gate_enable_zero;
  logic gate_polarity_zero;
  logic overflow_flag_zero;
  logic pre_tick;
  logic [1:0] sys_sel;
  logic [1:0] cl_tick;
  logic [1:0] run_en;
  logic [1:0] cl_ovf;
  logic th0_tick;
  logic th0_ovf;
  logic [15:0] cl_nx [2];
  logic [16:0] step;

  assign counter_select_zero = cls_q[0].counter_select;
  assign run_bit_zero = cls_q[0].run_bit;
  assign gate_enable_zero = cls_q[0].gate_enable;
  assign gate_polarity_zero = cls_q[0].gate_polarity;
  assign overflow_flag_zero = stat_q[ST_OVF0];
  assign sys_sel = {clkctl_q.timer1_sysclk_select, clkctl_q.timer0_sysclk_select};

  always_comb begin
    case (clkctl_q.shared_prescale_select)
      PRE_DIV12: pre_tick = tk[TK_D12];
      PRE_DIV4: pre_tick = tk[TK_D4];
      PRE_DIV48: pre_tick = tk[TK_D48];
      default: pre_tick = tk[TK_EXT8];
    endcase
  end

  // Upper half of timer 0 in split mode is a pure timer that uses timer 1's run bit.
  assign th0_tick = sys_sel[0] ? 1'b1 : pre_tick;

  always_comb begin
    step = 17'h00000;
    th0_ovf = 1'b0;
    for (int i = 0; i < 2; i++) begin
      // Counter select overrides the sysclk select; six sources in all.
      cl_tick[i] = cls_q[i].counter_select ? fall[IN_EV0 + i] : (sys_sel[i] ? 1'b1 : pre_tick);
      run_en[i] = cls_q[i].run_bit & (~cls_q[i].gate_enable | (lvl[IN_G0 + i] == cls_q[i].gate_polarity));
      cl_nx[i] = ccnt_q[i];
      cl_ovf[i] = 1'b0;
      step = classic_step(cls_q[i].mode, ccnt_q[i]);
      // Timer 1 holds its count in split mode.
      if (cl_tick[i] && run_en[i] && !(i == 1 && cls_q[i].mode == MODE_SPLIT)) begin
        cl_nx[i] = step[15:0];
        cl_ovf[i] = step[16];
      end
    end
    if (cls_q[0].mode == MODE_SPLIT && th0_tick && cls_q[1].run_bit) begin
      cl_nx[0][15:8] = ccnt_q[0][15:8] + 8'h01;
      th0_ovf = (ccnt_q[0][15:8] == CNT8_TOP);
    end
  end

  // A software write to a count wins over a step in the same cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ccnt_q[0] <= CNT_RST;
      ccnt_q[1] <= CNT_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_ccnt[i]) begin
          ccnt_q[i] <= merge16(ccnt_q[i], wb_dat_i[15:0], wb_sel_i[1:0]);
        end else begin
          ccnt_q[i] <= cl_nx[i];
        end
      end
    end
  end

  mode13_wrap_a: assert property (!wr_ccnt[0] && cl_tick[0] && run_en[0] && cls_q[0].mode == MODE_13BIT &&
      {ccnt_q[0][15:8], ccnt_q[0][4:0]} == CNT13_TOP |=> ccnt_q[0][15:8] == 8'h00 && ccnt_q[0][4:0] == 5'h00 &&
      overflow_flag_zero)
    else $error("13-bit wrap did not clear the count and set the flag");
  event_count_a: assert property (counter_select_zero && run_bit_zero && !gate_enable_zero && fall[IN_EV0] &&
      cls_q[0].mode == MODE_16BIT && !wr_ccnt[0] && ccnt_q[0] != CNT16_TOP |=> ccnt_q[0] == $past(ccnt_q[0]) + 16'h0001)
    else $error("event edge did not step the count by one");
  gate_block_a: assert property (!run_en[0] && !wr_ccnt[0] && cls_q[0].mode != MODE_SPLIT |=> $stable(ccnt_q[0]))
    else $error("timer counted while stopped or gated off");
  csel_ignore_a: assert property (counter_select_zero && !fall[IN_EV0] && !wr_ccnt[0] &&
      cls_q[0].mode != MODE_SPLIT |=> $stable(ccnt_q[0]))
    else $error("counter mode stepped without an event edge");
  sysclk_rate_a: assert property (!counter_select_zero && clkctl_q.timer0_sysclk_select && run_en[0] &&
      cls_q[0].mode == MODE_16BIT && !wr_ccnt[0] |=> ccnt_q[0] != $past(ccnt_q[0]))
    else $error("system clock source failed to step the timer");
  mode2_reload_a: assert property (cls_q[0].mode == MODE_8BIT_RELOAD && cl_tick[0] && run_en[0] &&
      !wr_ccnt[0] && ccnt_q[0][7:0] == CNT8_TOP |=> ccnt_q[0][7:0] == $past(ccnt_q[0][15:8]))
    else $error("8-bit reload did not load the high byte");
  div4_spacing_a: assert property (tk[TK_D4] |=> !tk[TK_D4] [*3] ##1 tk[TK_D4])
    else $error("divide by 4 tick spacing wrong");

  // Auto-reload timers with split, capture and alternate clocks.
  logic [1:0] a_tick_lo;
  logic [1:0] a_tick_hi;
  logic [1:0] a_ovf_lo;
  logic [1:0] a_ovf_hi;
  logic [1:0] cap_ev;
  logic [1:0] osc8;
  logic [15:0] an_cnt [2];

  assign osc8 = {tk[TK_EXT8], tk[TK_RTC8]};

  always_comb begin
    for (int j = 0; j < 2; j++) begin
      a_tick_lo[j] = (j == 0 ? clkctl_q.t2_lo_sys : clkctl_q.t3_lo_sys) ? 1'b1 :
                     aux_tick(actl_q[j].xclk, tk[TK_D12], osc8[j], fall[IN_CMP0 + j]);
      a_tick_hi[j] = (j == 0 ? clkctl_q.t2_hi_sys : clkctl_q.t3_hi_sys) ? 1'b1 :
                     aux_tick(actl_q[j].xclk, tk[TK_D12], osc8[j], fall[IN_CMP0 + j]);
      cap_ev[j] = actl_q[j].cap_en & (actl_q[j].cap_src ? rise[IN_CMP0 + j] : rise[IN_RTC]);
      an_cnt[j] = acnt_q[j];
      a_ovf_lo[j] = 1'b0;
      a_ovf_hi[j] = 1'b0;
      if (actl_q[j].run && actl_q[j].split && !actl_q[j].cap_en) begin
        if (a_tick_lo[j]) begin
          a_ovf_lo[j] = (acnt_q[j][7:0] == CNT8_TOP);
          an_cnt[j][7:0] = a_ovf_lo[j] ? arld_q[j][7:0] : acnt_q[j][7:0] + 8'h01;
        end
        if (a_tick_hi[j]) begin
          a_ovf_hi[j] = (acnt_q[j][15:8] == CNT8_TOP);
          an_cnt[j][15:8] = a_ovf_hi[j] ? arld_q[j][15:8] : acnt_q[j][15:8] + 8'h01;
        end
      end else if (actl_q[j].run && a_tick_lo[j]) begin
        a_ovf_hi[j] = (acnt_q[j] == CNT16_TOP);
        // In capture mode the reload register holds captures, so the count wraps to zero.
        if (a_ovf_hi[j]) begin
          an_cnt[j] = actl_q[j].cap_en ? CNT_RST : arld_q[j];
        end else begin
          an_cnt[j] = acnt_q[j] + 16'h0001;
        end
      end
    end
  end

  // A capture beats a software write of the reload register in the same cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int j = 0; j < 2; j++) begin
        acnt_q[j] <= CNT_RST;
        arld_q[j] <= CNT_RST;
      end
    end else begin
      for (int j = 0; j < 2; j++) begin
        if (wr_acnt[j]) begin
          acnt_q[j] <= merge16(acnt_q[j], wb_dat_i[15:0], wb_sel_i[1:0]);
        end else begin
          acnt_q[j] <= an_cnt[j];
        end
        if (cap_ev[j]) begin
          arld_q[j] <= acnt_q[j];
        end else if (wr_arld[j]) begin
          arld_q[j] <= merge16(arld_q[j], wb_dat_i[15:0], wb_sel_i[1:0]);
        end
      end
    end
  end

  auto_reload_a: assert property (actl_q[0].run && !actl_q[0].split && !actl_q[0].cap_en && a_tick_lo[0] &&
      acnt_q[0] == CNT16_TOP && !wr_acnt[0] |=> acnt_q[0] == $past(arld_q[0]))
    else $error("16-bit overflow did not reload the count");
  capture_take_a: assert property (cap_ev[0] |=> arld_q[0] == $past(acnt_q[0]) && stat_q[ST_CAP2])
    else $error("capture did not store the count and set its flag");
  div12_spacing_a: assert property (tk[TK_D12] |-> ##12 tk[TK_D12])
    else $error("divide by 12 tick spacing wrong");

  // Interrupt status: a set in the same cycle as its clear wins.
  logic [7:0] st_set;
  logic [7:0] clr_mask;
  logic [7:0] irq_en_d;

  always_comb begin
    st_set = 8'h00;
    st_set[ST_OVF0] = cl_ovf[0];
    st_set[ST_OVF1] = (cls_q[0].mode == MODE_SPLIT) ? th0_ovf : cl_ovf[1];
    for (int j = 0; j < 2; j++) begin
      st_set[ST_LO2 + 2 * j] = a_ovf_lo[j];
      st_set[ST_HI2 + 2 * j] = a_ovf_hi[j];
      st_set[ST_CAP2 + j] = cap_ev[j];
    end
    clr_mask = (wr_clr && wb_sel_i[0]) ? wb_dat_i[7:0] : 8'h00;
    stat_d = (stat_q & ~clr_mask) | st_set;
    irq_en_d = (wr_en && wb_sel_i[0]) ? wb_dat_i[7:0] : irq_en_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_q <= IRQ_RST;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      // The next enable is used so that irq never lags an enable write by a stale cycle.
      irq_q <= |(stat_d & irq_en_d);
    end
  end

  set_wins_a: assert property (st_set[ST_OVF0] && wr_clr && wb_sel_i[0] && wb_dat_i[ST_OVF0] |=> overflow_flag_zero)
    else $error("clear beat a coincident overflow");
  irq_level_a: assert property (irq_q == |(stat_q & irq_en_q))
    else $error("interrupt output disagrees with enabled status");

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign irq = irq_q;
endmodule : quad_timer_top
`default_nettype wire

// ==== sim/event_pins.sv ====
`timescale 1ns/1ps
`default_nettype none
module event_pins (
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] count,
  output logic busy,
  output logic pin,
  output logic osc
);
  logic [9:0] ph_q = 10'h000;
  logic [1:0] div_q = 2'h0;
  always @(posedge clk) begin
    div_q <= div_q + 2'h1;
    if (start) ph_q <= {count, 2'h0};
    else if (ph_q != 10'h000) ph_q <= ph_q - 10'h001;
  end
  // Each level lasts two clocks, so events arrive at a quarter of the clock rate.
  assign pin = ~((ph_q != 10'h000) && ph_q[1]);
  assign busy = (ph_q != 10'h000);
  assign osc = div_q[1];
endmodule : event_pins
`default_nettype wire

// ==== sim/quad_counter_timer_clocking_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module quad_counter_timer_clocking_test;
  import quad_timer_pkg::*;
  logic clk, sys_rst, cyc, stb, we, ack, irq, g0, g1, start, busy, pin, osc;
  logic [7:0] adr, cnt, ck, ca, na;
  logic [3:0] sel, gn;
  logic [31:0] wdat, rdat;
  logic [15:0] lfsr_q, v, on, mv, ex;
  logic [15:0] exp_q[$];
  int fails, cmp_count;
  logic [59:0] tb [14] = '{60'h1_04_04_0039_08_0060, 60'h0_04_04_0039_08_0000, 60'h0_00_04_0011_08_0008,
    60'h0_01_04_0011_08_0018, 60'h0_02_04_0011_08_0002, 60'h0_03_04_0011_08_0003, 60'h2_08_04_3900_0C_0060,
    60'h0_00_10_0001_14_0008, 60'h0_10_10_0001_14_0060, 60'h0_00_10_0005_14_0003, 60'h0_20_10_0003_14_6008,
    60'h0_00_1C_0001_20_0008, 60'h0_40_1C_0001_20_0060, 60'h0_00_1C_0005_20_0003};
  logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h3C};
  logic [7:0] ca4 [4] = '{8'h08, 8'h0C, 8'h14, 8'h20};
  `define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end

  quad_timer_top i_quad_timer_top (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq),
    .event_input_zero(pin), .event_input_one(pin), .gate_input_zero(g0), .gate_input_one(g1),
    .ext_osc_in(osc), .rtc_osc_in(osc), .comparator0_in(pin), .comparator1_in(pin));
  event_pins i_event_pins (.clk(clk), .start(start), .count(cnt), .busy(busy), .pin(pin), .osc(osc));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic end_sim();
    $display("fails %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  // A read notes its expected value; the watcher below compares it when ack shows.
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int k = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {16'h0000, d}; sel <= 4'h3;
    if (!w) exp_q.push_back(d);
    do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin fails++; end_sim(); end
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask : bus

  // Run for 96 edges; a multiple of every divider gives an exact tick count.
  task automatic window(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
    repeat (93) @(posedge clk);
    bus(1'b1, a, 16'h0000);
  endtask : window

  // Sends a burst of falling edges on the event pins and waits until the last one has passed the synchronisers.
  task automatic pulses(input logic [7:0] c);
    int n = 0;
    cnt <= c;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do begin @(posedge clk); n++; end while (busy !== 1'b0 && n < 300);
    if (n >= 300) begin fails++; end_sim(); end
    repeat (4) @(posedge clk);
  endtask : pulses

  always @(posedge clk) if (ack === 1'b1 && we === 1'b0) begin
    mv = exp_q.pop_front();
    `CHK("read", mv, rdat[15:0])
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {cyc, stb, we, start, g0, g1, sys_rst} = 7'h01;
    adr = 8'h00; sel = 4'h0; wdat = 32'h0; cnt = 8'h00; lfsr_q = 16'h68DB;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (ra[i]) bus(1'b0, ra[i], 16'h0000);
    foreach (tb[i]) begin
      {gn, ck, ca, on, na, ex} = tb[i];
      g0 <= gn[0]; g1 <= gn[1];
      v = lfsr_q & 16'h7F7F;
      lfsr_q = lfsr(lfsr_q);
      bus(1'b1, ADR_CLKCTL, {8'h00, ck});
      bus(1'b1, na, v);
      window(ca, on);
      bus(1'b0, na, v + ex);
    end
    bus(1'b1, ADR_CLKCTL, 16'h000C);
    foreach (ca4[i]) bus(1'b1, ca4[i], 16'h0000);
    bus(1'b1, ADR_CLASSIC, 16'h1515);
    bus(1'b1, ADR_ACTL2, 16'h0009);
    bus(1'b1, ADR_ACTL3, 16'h0009);
    pulses({3'h0, lfsr_q[4:0]} + 8'h01);
    foreach (ca4[i]) bus(1'b0, ca4[i], {8'h00, cnt});
    bus(1'b1, ADR_IRQ_EN, 16'h0001);
    bus(1'b1, ADR_CLKCTL, 16'h0004);
    bus(1'b1, ADR_CNT0, 16'hFF1F);
    bus(1'b1, ADR_CLASSIC, 16'h0010);
    bus(1'b1, ADR_CLASSIC, 16'h0000);
    bus(1'b0, ADR_CNT0, 16'h0002);
    bus(1'b0, ADR_IRQ_STAT, 16'h0001);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, ADR_IRQ_EN, 16'h0000);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, ADR_IRQ_EN, 16'h0001);
    bus(1'b1, ADR_IRQ_CLR, 16'h0001);
    bus(1'b0, ADR_IRQ_STAT, 16'h0000);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, ADR_CNT0, 16'hF0FE);
    bus(1'b1, ADR_CLASSIC, 16'h0012);
    bus(1'b1, ADR_CLASSIC, 16'h0000);
    bus(1'b0, ADR_CNT0, 16'hF0F1);
    bus(1'b1, ADR_CLASSIC, 16'h1313);
    bus(1'b1, ADR_CLASSIC, 16'h0000);
    bus(1'b0, ADR_CNT0, 16'hF3F4);
    bus(1'b0, ADR_CNT1, {8'h00, cnt});
    bus(1'b1, ADR_ACTL2, 16'h0000);
    bus(1'b1, ADR_CLKCTL, 16'h0010);
    bus(1'b1, ADR_ARLD2, 16'h1234);
    bus(1'b1, ADR_ACNT2, 16'hFFFE);
    bus(1'b1, ADR_ACTL2, 16'h0001);
    bus(1'b1, ADR_ACTL2, 16'h0030);
    bus(1'b0, ADR_ACNT2, 16'h1235);
    pulses(8'h01);
    bus(1'b0, ADR_ARLD2, 16'h1235);
    bus(1'b0, ADR_IRQ_STAT, 16'h0049);
    end_sim();
  end
endmodule : quad_counter_timer_clocking_test
`default_nettype wire
